// *** include/sbh_pkg.sv ***
// Constants, register map and state encoding of the serial byte host.
// Assumes a single 125 MHz core clock.
package sbh_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DATA = 8'hB0;
    localparam logic [7:0] OFS_INDEX = 8'hB1;
    localparam logic [7:0] OFS_TADDR = 8'hB2;
    localparam logic [7:0] OFS_CTRL = 8'hB3;

    // ------------------------------------------------------------
    // Reset values and control field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_INDEX = 8'h00;
    localparam logic [7:0] RST_TADDR = 8'h00;
    localparam int CTRL_PROT = 7;
    localparam int CTRL_BUSY = 5;
    localparam int CTRL_TEST = 2;
    localparam int CTRL_ERR = 1;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCL_PERIOD_NS = 10000;
    localparam int SCL_TEST_PERIOD_NS = 256;
    localparam logic [8:0] QTR_NORM =
        9'(SCL_PERIOD_NS / 4 / CLK_PERIOD_NS);
    localparam logic [8:0] QTR_TEST =
        9'(SCL_TEST_PERIOD_NS / 4 / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Transfer sequencer states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_START = 7'h02,
        ST_SEND = 7'h04,
        ST_GETACK = 7'h08,
        ST_RECV = 7'h10,
        ST_PUTACK = 7'h20,
        ST_STOP = 7'h40
    } sbh_state_t;

endpackage : sbh_pkg

// *** logic/sbh_sync3.sv ***
// Three-stage input synchroniser with agreement filter.
// Assumes din is asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module sbh_sync3 (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic din,
    output logic dout
);
    logic s1_q, s2_q, s3_q, out_q;
    logic out_d;

    always_comb begin
        // Only a level held in both late stages counts
        out_d = (s2_q == s3_q) ? s2_q : out_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            out_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule : sbh_sync3
`default_nettype wire

// *** logic/sbh_host.sv ***
// Software-driven two-wire bus master for single byte reads and writes.
// Assumes open-drain pins resolved outside; pull-ups keep idle lines high.
`timescale 1ns/1ps
`default_nettype none
module sbh_host (
    // Clock and global reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] cfg_addr,
    input wire logic cfg_wr_en,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_rd_en,
    output logic [7:0] cfg_rdata,
    // Two-wire bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sbh_pkg::sbh_state_t st_q, st_d;
    logic [1:0] ph_q, ph_d;
    logic [2:0] bit_q, bit_d;
    logic [1:0] stage_q, stage_d;
    logic [7:0] shift_q, shift_d;
    logic [8:0] div_q, div_d;
    logic scl_low_q, scl_low_d;
    logic sda_low_q, sda_low_d;
    logic nack_q, nack_d;
    logic short_q, short_d;
    logic [7:0] data_q, data_d;
    logic [7:0] index_q, index_d;
    logic [7:0] taddr_q, taddr_d;
    logic prot_q, prot_d;
    logic test_q, test_d;
    logic err_q, err_d;
    logic [7:0] rdata_q, rdata_d;
    logic scl_s, sda_s;
    logic idle, tick, stall, advance, rw;
    logic wr_data, wr_index, wr_taddr, wr_ctrl;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sbh_sync3 u_scl_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .din(scl_i),
        .dout(scl_s)
    );
    sbh_sync3 u_sda_sync (
        .clk(core_clk),
        .rst_n(rst_n),
        .din(sda_i),
        .dout(sda_s)
    );

    assign idle = (st_q == sbh_pkg::ST_IDLE);
    assign rw = taddr_q[0];
    assign tick = !idle && (div_q == 9'h000);
    // Hold the high phase while a target stretches the clock
    assign stall = (st_q != sbh_pkg::ST_START) && (ph_q == 2'h1) &&
        !scl_s;
    assign advance = tick && !stall;
    assign wr_data = cfg_wr_en && (cfg_addr == sbh_pkg::OFS_DATA);
    assign wr_index = cfg_wr_en && (cfg_addr == sbh_pkg::OFS_INDEX);
    assign wr_taddr = cfg_wr_en && (cfg_addr == sbh_pkg::OFS_TADDR);
    assign wr_ctrl = cfg_wr_en && (cfg_addr == sbh_pkg::OFS_CTRL);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        bit_d = bit_q;
        stage_d = stage_q;
        shift_d = shift_q;
        scl_low_d = scl_low_q;
        sda_low_d = sda_low_q;
        nack_d = nack_q;
        short_d = short_q;
        data_d = data_q;
        index_d = index_q;
        taddr_d = taddr_q;
        prot_d = prot_q;
        test_d = test_q;
        err_d = err_q;
        rdata_d = rdata_q;
        div_d = div_q;

        // Register writes; transfer registers frozen while busy
        if (wr_data && idle) data_d = cfg_wdata;
        if (wr_index && idle) index_d = cfg_wdata;
        if (wr_taddr && idle) begin
            taddr_d = cfg_wdata;
            st_d = sbh_pkg::ST_START;
            ph_d = 2'h0;
            stage_d = 2'h0;
            bit_d = 3'h0;
            short_d = prot_q;
        end
        if (wr_ctrl) begin
            prot_d = cfg_wdata[sbh_pkg::CTRL_PROT];
            test_d = cfg_wdata[sbh_pkg::CTRL_TEST];
            if (cfg_wdata[sbh_pkg::CTRL_ERR]) err_d = 1'b0;
        end

        // Quarter-bit divider
        if (idle || advance) begin
            div_d = (test_q ? sbh_pkg::QTR_TEST : sbh_pkg::QTR_NORM) -
                9'h001;
        end else if (!tick) begin
            div_d = div_q - 9'h001;
        end

        // Actions at the end of each quarter
        if (advance) begin
            ph_d = ph_q + 2'h1;
            case (st_q)
                sbh_pkg::ST_START: begin
                    case (ph_q)
                        2'h0: sda_low_d = 1'b0;
                        2'h1: scl_low_d = 1'b0;
                        2'h2: sda_low_d = 1'b1;
                        default: begin
                            scl_low_d = 1'b1;
                            st_d = sbh_pkg::ST_SEND;
                            shift_d = {taddr_q[7:1],
                                (stage_q == 2'h2) | (short_q & rw)};
                            sda_low_d = ~shift_d[7];
                        end
                    endcase
                end
                sbh_pkg::ST_SEND, sbh_pkg::ST_GETACK,
                sbh_pkg::ST_RECV, sbh_pkg::ST_PUTACK: begin
                    case (ph_q)
                        2'h0: scl_low_d = 1'b0;
                        2'h1: begin
                            nack_d = sda_s;
                            if (st_q == sbh_pkg::ST_RECV) begin
                                shift_d = {shift_q[6:0], sda_s};
                            end
                        end
                        2'h2: scl_low_d = 1'b1;
                        default: begin
                            // Acknowledge slots must not move the bit count
                            if (st_q == sbh_pkg::ST_SEND ||
                                st_q == sbh_pkg::ST_RECV) begin
                                bit_d = bit_q + 3'h1;
                            end
                            if (st_q == sbh_pkg::ST_SEND) begin
                                if (bit_q == 3'h7) begin
                                    st_d = sbh_pkg::ST_GETACK;
                                    sda_low_d = 1'b0;
                                end else begin
                                    shift_d = {shift_q[6:0], 1'b0};
                                    sda_low_d = ~shift_q[6];
                                end
                            end else if (st_q == sbh_pkg::ST_RECV) begin
                                if (bit_q == 3'h7) begin
                                    st_d = sbh_pkg::ST_PUTACK;
                                    data_d = shift_q;
                                    sda_low_d = 1'b0;
                                end
                            end else if (st_q == sbh_pkg::ST_PUTACK) begin
                                st_d = sbh_pkg::ST_STOP;
                                sda_low_d = 1'b1;
                            end else if (nack_q) begin
                                err_d = 1'b1;
                                st_d = sbh_pkg::ST_STOP;
                                sda_low_d = 1'b1;
                            end else if (stage_q == 2'h0 && short_q) begin
                                // Index byte skipped
                                stage_d = 2'h2;
                                st_d = rw ? sbh_pkg::ST_RECV :
                                    sbh_pkg::ST_SEND;
                                shift_d = data_q;
                                sda_low_d = rw ? 1'b0 : ~data_q[7];
                            end else if (stage_q == 2'h0) begin
                                stage_d = 2'h1;
                                st_d = sbh_pkg::ST_SEND;
                                shift_d = index_q;
                                sda_low_d = ~index_q[7];
                            end else if (stage_q == 2'h1 && rw) begin
                                stage_d = 2'h2;
                                st_d = sbh_pkg::ST_START;
                                sda_low_d = 1'b0;
                            end else if (stage_q == 2'h1) begin
                                stage_d = 2'h2;
                                st_d = sbh_pkg::ST_SEND;
                                shift_d = data_q;
                                sda_low_d = ~data_q[7];
                            end else begin
                                st_d = rw ? sbh_pkg::ST_RECV :
                                    sbh_pkg::ST_STOP;
                                sda_low_d = !rw;
                            end
                        end
                    endcase
                end
                sbh_pkg::ST_STOP: begin
                    case (ph_q)
                        2'h0: scl_low_d = 1'b0;
                        2'h1: sda_low_d = 1'b0;
                        2'h2: sda_low_d = 1'b0;
                        default: st_d = sbh_pkg::ST_IDLE;
                    endcase
                end
                default: st_d = sbh_pkg::ST_IDLE;
            endcase
        end

        // Register read port, unmapped offsets read zero
        if (cfg_rd_en) begin
            case (cfg_addr)
                sbh_pkg::OFS_DATA: rdata_d = data_q;
                sbh_pkg::OFS_INDEX: rdata_d = index_q;
                sbh_pkg::OFS_TADDR: rdata_d = taddr_q;
                sbh_pkg::OFS_CTRL: rdata_d = {prot_q, 1'b0, !idle,
                    2'b00, test_q, err_q, 1'b0};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers, cleared by the global reset; err_q also by a write of one
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= sbh_pkg::ST_IDLE;
            ph_q <= 2'h0;
            bit_q <= 3'h0;
            stage_q <= 2'h0;
            shift_q <= 8'h00;
            div_q <= 9'h000;
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
            nack_q <= 1'b0;
            short_q <= 1'b0;
            data_q <= sbh_pkg::RST_DATA;
            index_q <= sbh_pkg::RST_INDEX;
            taddr_q <= sbh_pkg::RST_TADDR;
            prot_q <= 1'b0;
            test_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            st_q <= st_d;
            ph_q <= ph_d;
            bit_q <= bit_d;
            stage_q <= stage_d;
            shift_q <= shift_d;
            div_q <= div_d;
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
            nack_q <= nack_d;
            short_q <= short_d;
            data_q <= data_d;
            index_q <= index_d;
            taddr_q <= taddr_d;
            prot_q <= prot_d;
            test_q <= test_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // Open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = scl_low_q;
    assign sda_oe = sda_low_q;
    assign cfg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking chk_cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_busy_on_start: assert property (
        (wr_taddr && idle) |=> (st_q == sbh_pkg::ST_START))
        else $error("address write did not start transfer");
    chk_busy_clear_stop: assert property (
        (st_q == sbh_pkg::ST_STOP && advance && ph_q == 2'h3) |=> idle)
        else $error("busy not cleared after stop");
    chk_err_w1c: assert property (
        (err_q && wr_ctrl && cfg_wdata[1] && st_q != sbh_pkg::ST_GETACK)
        |=> !err_q)
        else $error("error flag not cleared by write one");
    chk_err_sticky: assert property (
        (err_q && !(wr_ctrl && cfg_wdata[1])) |=> err_q)
        else $error("error flag dropped");
    chk_data_hold: assert property (
        (idle && !wr_data) |=> $stable(data_q))
        else $error("data register changed while idle");
    chk_load_first: assert property (
        (st_q == sbh_pkg::ST_START && advance && ph_q == 2'h3 &&
        stage_q == 2'h0) |=> (shift_q == {taddr_q[7:1], short_q & rw}))
        else $error("first address byte wrong");
    chk_short_no_index: assert property (
        (stage_q == 2'h1) |-> !short_q)
        else $error("index byte sent in short protocol");
    chk_quarter_gap: assert property (
        advance |=> !advance [*7])
        else $error("bus clock quarter too short");
    chk_idle_release: assert property (
        (idle && $past(idle)) |-> (!scl_oe && !sda_oe))
        else $error("bus driven while idle");
    chk_read_data: assert property (
        (cfg_rd_en && cfg_addr == sbh_pkg::OFS_DATA) |=>
        (cfg_rdata == $past(data_q)))
        else $error("data register read mismatch");
endmodule : sbh_host
`default_nettype wire

// *** dv/sbh_target_model.sv ***
// Behavioural two-wire target: byte memory behind an index pointer.
// Assumes pull-ups on both wires; it never stretches the clock.
`timescale 1ns/1ps
`default_nettype none
module sbh_target_model #(
    parameter logic [6:0] OWN_ADDR = 7'h50
) (
    // Wire levels
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    // Observed traffic
    output logic [7:0] got_addr,
    output logic [7:0] got_index,
    output logic [7:0] got_data,
    output int n_bytes,
    output int n_start
);
    logic [7:0] mem [256];
    logic [7:0] ptr;
    logic [7:0] b;
    int ev;

    // ------------------------------------------------------------
    // Bit level
    // ------------------------------------------------------------
    // Ends at the falling clock after bit 0; e is 1 on start, 2 on stop
    task automatic rx_byte(output logic [7:0] d, output int e);
        logic v;
        int i;
        e = 0;
        for (i = 7; i >= 0; i--) begin
            @(posedge scl);
            v = sda;
            d[i] = v;
            while (scl === 1'b1) begin
                @(scl or sda);
                if (scl === 1'b1 && sda !== v) begin
                    e = v ? 1 : 2;
                    return;
                end
            end
        end
    endtask : rx_byte

    task automatic put_ack(input logic a);
        sda_pull = a;
        @(negedge scl);
        sda_pull = 1'b0;
    endtask : put_ack

    // Data changes only while the clock is low
    task automatic tx_byte(input logic [7:0] d);
        int i;
        for (i = 7; i >= 0; i--) begin
            sda_pull = ~d[i];
            @(negedge scl);
        end
        sda_pull = 1'b0;
    endtask : tx_byte

    // ------------------------------------------------------------
    // Frame level
    // ------------------------------------------------------------
    initial begin
        sda_pull = 1'b0;
        got_addr = 8'h00;
        got_index = 8'h00;
        got_data = 8'h00;
        n_bytes = 0;
        n_start = 0;
        ptr = 8'h00;
        forever begin
            @(negedge sda iff scl === 1'b1);
            ev = 1;
            while (ev == 1) begin
                n_start++;
                n_bytes = 0;
                rx_byte(b, ev);
                if (ev == 0) begin
                    got_addr = b;
                    put_ack(b[7:1] == OWN_ADDR);
                    if (b[7:1] == OWN_ADDR && b[0] == 1'b1) begin
                        tx_byte(mem[ptr]);
                        ptr++;
                    end
                    rx_byte(b, ev);
                    while (ev == 0) begin
                        if (got_addr[7:1] == OWN_ADDR && !got_addr[0]) begin
                            if (n_bytes == 0) begin
                                ptr = b;
                                got_index = b;
                            end else begin
                                mem[ptr] = b;
                                got_data = b;
                                ptr++;
                            end
                            n_bytes++;
                            put_ack(1'b1);
                        end
                        rx_byte(b, ev);
                    end
                end
            end
        end
    end
endmodule : sbh_target_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench of the serial byte host through its register port.
// Assumes the target model answers at 7'h50 and pull-ups on both wires.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("[ERR] %s expected %h seen %h", nm, exp, got); \
    end \
end
module tb;
    logic core_clk, rst_n, cfg_wr_en, cfg_rd_en, sda_pull;
    logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, rv;
    logic scl_o, scl_oe, sda_o, sda_oe, scl_w, sda_w;
    logic [7:0] got_addr, got_index, got_data;
    int n_bytes, n_start, ns0;
    int n_mismatch = 0;
    int tests_run = 0;
    assign scl_w = ~scl_oe;
    assign sda_w = ~(sda_oe | sda_pull);
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    sbh_host dut_u (.core_clk(core_clk), .rst_n(rst_n),
        .cfg_addr(cfg_addr), .cfg_wr_en(cfg_wr_en), .cfg_wdata(cfg_wdata),
        .cfg_rd_en(cfg_rd_en), .cfg_rdata(cfg_rdata), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe(sda_oe));
    sbh_target_model tgt_u (.scl(scl_w), .sda(sda_w), .sda_pull(sda_pull),
        .got_addr(got_addr), .got_index(got_index), .got_data(got_data),
        .n_bytes(n_bytes), .n_start(n_start));

    // ------------------------------------------------------------
    // Register port tasks, entered at a falling edge
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    // Idle cycle after each strobe so no strobe is set twice at one time
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr_en = 1'b1;
        @(negedge core_clk);
        cfg_wr_en = 1'b0;
        @(negedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        cfg_addr = a;
        cfg_rd_en = 1'b1;
        @(negedge core_clk);
        cfg_rd_en = 1'b0;
        d = cfg_rdata;
        @(negedge core_clk);
    endtask : rd

    task automatic cmp_reg(input logic [7:0] a, input logic [7:0] e);
        rd(a, rv);
        `CHK("register", e, rv)
    endtask : cmp_reg

    task automatic wait_idle();
        int i;
        for (i = 0; i < 20000; i++) begin
            rd(sbh_pkg::OFS_CTRL, rv);
            if (rv[sbh_pkg::CTRL_BUSY] === 1'b0) return;
        end
        n_mismatch++;
        $display("[ERR] busy flag expected 0 seen 1");
        give_verdict();
    endtask : wait_idle

    // Spacing of the second and third falling clock edges
    task automatic scl_period(input int q);
        time t1;
        logic prev;
        int i, k;
        k = 0;
        t1 = 0;
        prev = scl_w;
        for (i = 0; i < 8000 && k < 3; i++) begin
            @(posedge core_clk);
            if (prev === 1'b1 && scl_w === 1'b0) begin
                if (k == 2) `CHK("scl period", 4 * q * 8, int'($time - t1))
                t1 = $time;
                k++;
            end
            prev = scl_w;
        end
        `CHK("scl edges", 3, k)
        @(negedge core_clk);
    endtask : scl_period

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        cfg_addr = 8'h00;
        cfg_wdata = 8'h00;
        cfg_wr_en = 1'b0;
        cfg_rd_en = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        cmp_reg(sbh_pkg::OFS_DATA, 8'h00);
        cmp_reg(sbh_pkg::OFS_INDEX, 8'h00);
        cmp_reg(sbh_pkg::OFS_TADDR, 8'h00);
        cmp_reg(sbh_pkg::OFS_CTRL, 8'h00);
        wr(sbh_pkg::OFS_DATA, 8'hA5);
        wr(sbh_pkg::OFS_INDEX, 8'h3C);
        wr(8'hB4, 8'h5A);
        cmp_reg(sbh_pkg::OFS_DATA, 8'hA5);
        cmp_reg(sbh_pkg::OFS_INDEX, 8'h3C);
        cmp_reg(8'hB4, 8'h00);
        `CHK("pin levels", 2'b00, {scl_o, sda_o})
        // Full byte write at the test rate
        wr(sbh_pkg::OFS_CTRL, 8'h04);
        wr(sbh_pkg::OFS_DATA, 8'h5A);
        wr(sbh_pkg::OFS_INDEX, 8'h10);
        wr(sbh_pkg::OFS_TADDR, 8'hA0);
        cmp_reg(sbh_pkg::OFS_CTRL, 8'h24);
        wr(sbh_pkg::OFS_DATA, 8'hFF);
        scl_period(int'(sbh_pkg::QTR_TEST));
        wait_idle();
        `CHK("target address", 8'hA0, got_addr)
        `CHK("index byte", 8'h10, got_index)
        `CHK("data byte", 8'h5A, got_data)
        `CHK("bytes after address", 2, n_bytes)
        cmp_reg(sbh_pkg::OFS_DATA, 8'h5A);
        // Full byte read
        tgt_u.mem[8'h22] = 8'hC3;
        wr(sbh_pkg::OFS_INDEX, 8'h22);
        ns0 = n_start;
        wr(sbh_pkg::OFS_TADDR, 8'hA1);
        wait_idle();
        cmp_reg(sbh_pkg::OFS_DATA, 8'hC3);
        `CHK("starts in read", ns0 + 2, n_start)
        `CHK("read address", 8'hA1, got_addr)
        // No answer from an absent target; error bit cleared by one
        wr(sbh_pkg::OFS_TADDR, 8'h66);
        wait_idle();
        cmp_reg(sbh_pkg::OFS_CTRL, 8'h06);
        wr(sbh_pkg::OFS_CTRL, 8'h06);
        cmp_reg(sbh_pkg::OFS_CTRL, 8'h04);
        // Short protocol, index byte left out
        wr(sbh_pkg::OFS_CTRL, 8'h84);
        wr(sbh_pkg::OFS_DATA, 8'h77);
        wr(sbh_pkg::OFS_TADDR, 8'hA0);
        wait_idle();
        `CHK("short write bytes", 1, n_bytes)
        `CHK("short write byte", 8'h77, got_index)
        tgt_u.mem[8'h77] = 8'h9E;
        ns0 = n_start;
        wr(sbh_pkg::OFS_TADDR, 8'hA1);
        wait_idle();
        cmp_reg(sbh_pkg::OFS_DATA, 8'h9E);
        `CHK("starts in short read", ns0 + 1, n_start)
        // Normal rate
        wr(sbh_pkg::OFS_CTRL, 8'h80);
        wr(sbh_pkg::OFS_TADDR, 8'hA0);
        scl_period(int'(sbh_pkg::QTR_NORM));
        wait_idle();
        // Reset in mid-transfer
        wr(sbh_pkg::OFS_TADDR, 8'hA0);
        // Cut the frame inside the first address bit
        repeat (2000) @(negedge core_clk);
        rst_n = 1'b0;
        @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        `CHK("pin enables", 2'b00, {scl_oe, sda_oe})
        cmp_reg(sbh_pkg::OFS_DATA, 8'h00);
        cmp_reg(sbh_pkg::OFS_TADDR, 8'h00);
        cmp_reg(sbh_pkg::OFS_CTRL, 8'h00);
        give_verdict();
    end
endmodule : tb
`default_nettype wire
